// ---- design/slb_seq.sv ----
/*
 split-lock bus sequencer: issues two partial reads and two partial writes
 under bus lock, honouring block-next-request, releasing lock after the
 fourth response.
 assumes all bus inputs synchronous to clk_i; responses return in order.
*/
`include "slb_defs.svh"
module slb_seq #(
   parameter int IOQ_DEPTH = `SLB_IOQ_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire slb_pkg::slb_req_type req_i,
   input wire logic block_next_request_n_i,
   input wire logic response_status_n_i,
   output logic busy_o,
   output logic done_o,
   output logic address_strobe_n_o,
   output logic lock_n_o,
   output slb_pkg::slb_xact_type xact_o
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_b;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_reg <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_b <= rst_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   slb_pkg::slb_state_type state_reg, state_next;
   slb_pkg::slb_req_type req_reg;
   slb_pkg::slb_xact_type xact_reg;
   logic lock_reg;
   logic strobe_reg;
   logic done_reg;
   logic [2:0] issued;
   logic [2:0] answered;

   function automatic slb_pkg::slb_xact_type xact_of(
      input logic [2:0] idx, input slb_pkg::slb_req_type r);
      slb_pkg::slb_xact_type x;
      x.kind = idx[1] ? `SLB_KIND_WR : `SLB_KIND_RD;
      x.addr = idx[0] ? r.addr_hi : r.addr_lo;
      x.data = idx[1] ? r.wdata : '0;
      return x;
   endfunction

   wire blocked = !block_next_request_n_i;
   wire resp = !response_status_n_i;
   wire outstanding_full = (3'(issued - answered) >= 3'(IOQ_DEPTH));
   wire can_issue = (state_reg == slb_pkg::SLB_ISSUE) && !blocked
                    && !outstanding_full && !strobe_reg;
   wire last_resp = resp && (answered == `SLB_NUM_XACT - 3'h1)
                    && (issued == `SLB_NUM_XACT);
   wire clear = (state_reg == slb_pkg::SLB_IDLE) && start_i;

   slb_resp_count u_count (
      .clk_i(clk_i),
      .rst_b_i(rst_b),
      .ce_i(ce_i),
      .clear_i(clear),
      .strobe_i(can_issue),
      .resp_i(resp && state_reg != slb_pkg::SLB_IDLE),
      .issued_o(issued),
      .answered_o(answered)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         slb_pkg::SLB_IDLE: begin
            if (start_i) state_next = slb_pkg::SLB_ISSUE;
         end
         slb_pkg::SLB_ISSUE: begin
            if (can_issue && issued == `SLB_NUM_XACT - 3'h1)
               state_next = slb_pkg::SLB_WAIT_RESP;
         end
         slb_pkg::SLB_WAIT_RESP: begin
            if (last_resp) state_next = slb_pkg::SLB_DONE;
         end
         slb_pkg::SLB_DONE: begin
            state_next = slb_pkg::SLB_IDLE;
         end
         default: begin
            state_next = slb_pkg::SLB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= slb_pkg::SLB_IDLE;
         req_reg <= '0;
         xact_reg <= '0;
         lock_reg <= 1'b0;
         strobe_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         strobe_reg <= can_issue;
         done_reg <= (state_next == slb_pkg::SLB_DONE);
         if (clear) req_reg <= req_i;
         // lock rises with the first strobe, falls only on last answer
         if (can_issue) lock_reg <= 1'b1;
         else if (state_reg == slb_pkg::SLB_WAIT_RESP && last_resp)
            lock_reg <= 1'b0;
         if (can_issue) xact_reg <= xact_of(issued, req_reg);
      end
   end

   // strobe and lock leave flip-flops together so lock covers strobe 1
   assign address_strobe_n_o = !strobe_reg;
   assign lock_n_o = !lock_reg;
   assign xact_o = xact_reg;
   assign busy_o = (state_reg != slb_pkg::SLB_IDLE);
   assign done_o = done_reg;

   // ------------------------------------------------------------
   // checks: lock
   // ------------------------------------------------------------
   a_lock_rise_first: assert property (@(posedge clk_i) disable iff (!rst_b)
      $fell(lock_n_o) |-> !address_strobe_n_o)
      else $error("lock raised without first strobe");
   a_idle_unlocked: assert property (@(posedge clk_i) disable iff (!rst_b)
      (state_reg == slb_pkg::SLB_IDLE) |-> lock_n_o)
      else $error("lock held while idle");
   a_lock_busy: assert property (@(posedge clk_i) disable iff (!rst_b)
      !lock_n_o |-> busy_o)
      else $error("lock held outside a sequence");

   // ------------------------------------------------------------
   // checks: freeze and pulses
   // ------------------------------------------------------------
   // a low enable must leave state_reg and lock_n_o where they were
   a_freeze_hold: assert property (@(posedge clk_i) disable iff (!rst_b)
      !ce_i |=> $stable(state_reg) && $stable(lock_n_o))
      else $error("state moved while frozen");
   a_strobe_spacing: assert property (@(posedge clk_i) disable iff (!rst_b)
      !address_strobe_n_o |=> address_strobe_n_o)
      else $error("strobes back to back");
   a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_b)
      done_o |=> !done_o)
      else $error("done longer than one cycle");

   // ------------------------------------------------------------
   // checks: transaction contents
   // ------------------------------------------------------------
   a_first_addr: assert property (@(posedge clk_i) disable iff (!rst_b)
      (!address_strobe_n_o && issued == 3'h1)
      |-> xact_o.addr == req_reg.addr_lo)
      else $error("first strobe address wrong");
   a_second_addr: assert property (@(posedge clk_i) disable iff (!rst_b)
      (!address_strobe_n_o && issued == 3'h2)
      |-> xact_o.addr == req_reg.addr_hi)
      else $error("second strobe address wrong");
   a_write_data: assert property (@(posedge clk_i) disable iff (!rst_b)
      (!address_strobe_n_o && issued >= 3'h3)
      |-> xact_o.data == req_reg.wdata)
      else $error("write data wrong");

   // ------------------------------------------------------------
   // checks: order and queue
   // ------------------------------------------------------------
   a_lock_over_strobe: assert property (@(posedge clk_i) disable iff (!rst_b)
      !address_strobe_n_o |-> !lock_n_o)
      else $error("strobe without lock");
   a_no_strobe_blocked: assert property (@(posedge clk_i) disable iff (!rst_b)
      (ce_i && blocked) |=> address_strobe_n_o)
      else $error("strobe issued while blocked");
   a_lock_held_resp: assert property (@(posedge clk_i) disable iff (!rst_b)
      ($rose(lock_n_o)) |-> $past(answered) == 3'h3 && $past(resp))
      else $error("lock released before fourth response");
   a_write_order: assert property (@(posedge clk_i) disable iff (!rst_b)
      (!address_strobe_n_o && issued >= 3'h3) |-> xact_o.kind)
      else $error("late strobe not a write");
   a_read_order: assert property (@(posedge clk_i) disable iff (!rst_b)
      (!address_strobe_n_o && issued <= 3'h2) |-> !xact_o.kind)
      else $error("early strobe not a read");
   a_four_max: assert property (@(posedge clk_i) disable iff (!rst_b)
      issued <= `SLB_NUM_XACT)
      else $error("more than four strobes");
   a_ioq_limit: assert property (@(posedge clk_i) disable iff (!rst_b)
      3'(issued - answered) <= 3'(IOQ_DEPTH))
      else $error("queue depth exceeded");
   a_done_unlocked: assert property (@(posedge clk_i) disable iff (!rst_b)
      done_o |-> lock_n_o ##1 !busy_o)
      else $error("done while locked");
   c_full_seq: cover property (@(posedge clk_i) disable iff (!rst_b)
      done_o);
   c_block_after_third: cover property (@(posedge clk_i) disable iff (!rst_b)
      issued == 3'h3 && blocked && state_reg == slb_pkg::SLB_ISSUE);
   c_queue_full: cover property (@(posedge clk_i) disable iff (!rst_b)
      outstanding_full && state_reg == slb_pkg::SLB_ISSUE);
   c_frozen_busy: cover property (@(posedge clk_i) disable iff (!rst_b)
      !ce_i && busy_o);
   c_fourth_strobe: cover property (@(posedge clk_i) disable iff (!rst_b)
      !address_strobe_n_o && issued == `SLB_NUM_XACT);
endmodule

// ---- design/slb_defs.svh ----
/*
 constants for the split-lock bus sequencer: counts, widths and encodings.
 assumes inclusion by bare name from design files.
*/
`ifndef SLB_DEFS_SVH
`define SLB_DEFS_SVH
`define SLB_NUM_XACT 3'h4
`define SLB_IOQ_DEPTH 2
`define SLB_KIND_RD 1'h0
`define SLB_KIND_WR 1'h1
`define SLB_ADDR_W 32
`define SLB_DATA_W 64
`endif

// ---- design/slb_pkg.sv ----
/*
 types for the split-lock bus sequencer.
 assumes slb_defs.svh is on the include path.
*/
`include "slb_defs.svh"
package slb_pkg;
   typedef struct packed {
      logic [`SLB_ADDR_W-1:0] addr_lo;
      logic [`SLB_ADDR_W-1:0] addr_hi;
      logic [`SLB_DATA_W-1:0] wdata;
   } slb_req_type;
   typedef struct packed {
      logic kind;
      logic [`SLB_ADDR_W-1:0] addr;
      logic [`SLB_DATA_W-1:0] data;
   } slb_xact_type;
   typedef enum logic [2:0] {
      SLB_IDLE,
      SLB_ISSUE,
      SLB_WAIT_RESP,
      SLB_DONE
   } slb_state_type;
endpackage

// ---- design/slb_resp_count.sv ----
/*
 counts issued transactions and sampled responses of one locked sequence.
 assumes one response per issued strobe, in order.
*/
`include "slb_defs.svh"
module slb_resp_count (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic clear_i,
   input wire logic strobe_i,
   input wire logic resp_i,
   output logic [2:0] issued_o,
   output logic [2:0] answered_o
);
   logic [2:0] issued_reg;
   logic [2:0] answered_reg;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         issued_reg <= 3'h0;
         answered_reg <= 3'h0;
      end else if (ce_i) begin
         if (clear_i) begin
            issued_reg <= 3'h0;
            answered_reg <= 3'h0;
         end else begin
            if (strobe_i) issued_reg <= issued_reg + 3'h1;
            if (resp_i) answered_reg <= answered_reg + 3'h1;
         end
      end
   end
   assign issued_o = issued_reg;
   assign answered_o = answered_reg;
endmodule

// ---- tb/slb_agent_model.sv ----
/* chipset agent model: one response pulse per strobe, in order.
 assumes strobes come from the sequencer on clk_i; dly_i >= 1. */
module slb_agent_model (
   input wire logic clk_i,
   input wire logic strobe_n_i,
   input wire logic blk_i,
   input wire logic [3:0] dly_i,
   output logic resp_n_o,
   output logic bnr_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int pend = 0;
   int cnt = 0;
   // lock is not watched, so an early release is tolerated
   assign bnr_n_o = !blk_i;
   always @(posedge clk_i) begin
      if (strobe_n_i === 1'b0)
         pend++;
      resp_n_o <= 1'b1;
      if (pend > 0) begin
         cnt++;
         // a high cycle between pulses keeps responses countable
         if (cnt >= dly_i && resp_n_o) begin
            resp_n_o <= 1'b0;
            pend--;
            cnt = 0;
         end
      end
   end
endmodule

// ---- tb/slb_seq_tb_top.sv ----
/* testbench of the split-lock sequencer against the agent model.
 assumes the design files are compiled first. */
module slb_seq_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_b = 0, ce = 1, start = 0, blk = 0, lk_q = 1;
   logic busy, done, strobe_n, lock_n, resp_n, bnr_n;
   logic [3:0] dly = 4'h1;
   slb_pkg::slb_req_type req = '0;
   slb_pkg::slb_xact_type xact;
   slb_pkg::slb_xact_type log_q [8];
   int ns, nr, failures = 0, n_checks = 0, cyc = 0;
   slb_seq i_slb_seq (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
      .start_i(start), .req_i(req), .block_next_request_n_i(bnr_n),
      .response_status_n_i(resp_n), .busy_o(busy), .done_o(done),
      .address_strobe_n_o(strobe_n), .lock_n_o(lock_n), .xact_o(xact));
   slb_agent_model i_slb_agent_model (.clk_i(clk), .strobe_n_i(strobe_n),
      .blk_i(blk), .dly_i(dly), .resp_n_o(resp_n), .bnr_n_o(bnr_n));
   initial forever #2 clk = !clk;
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // sampled mid-cycle so registered outputs have settled
   always @(negedge clk) begin
      if (strobe_n === 1'b0) begin
         chk(lock_n, 1'b0);
         chk(ns - nr <= 2, 1'b1);
         if (ns < 8)
            log_q[ns] = xact;
         ns++;
      end
      if (resp_n === 1'b0)
         nr++;
      if (lock_n === 1'b1 && lk_q === 1'b0) chk(nr, 4);
      lk_q = lock_n;
   end
   task automatic run(input logic b, input logic f);
      int k;
      ns = 0;
      nr = 0;
      req = '{32'h1000_00FC, 32'h1000_0100, 64'hA5A5_0000_0000_5A5A};
      start = 1'b1;
      @(posedge clk) #1;
      start = 1'b0;
      chk(busy, 1'b1);
      if (f) begin
         ce = 1'b0;
         repeat (6) @(posedge clk) #1;
         chk(ns, 0);
         chk(lock_n, 1'b1);
         ce = 1'b1;
      end
      if (b) begin
         for (k = 0; k < 200 && ns < 3; k++) @(posedge clk) #1;
         blk = 1'b1;
         repeat (8) @(posedge clk) #1;
         chk(ns, 3);
         blk = 1'b0;
      end
      for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk) #1;
      chk(ns, 4);
      chk(lock_n, 1'b1);
      for (k = 0; k < 4; k++) begin
         chk(log_q[k].kind, k > 1);
         chk(log_q[k].addr, k % 2 ? req.addr_hi : req.addr_lo);
         chk(log_q[k].data, k > 1 ? req.wdata : 64'h0);
      end
      repeat (2) @(posedge clk) #1;
      chk(busy, 1'b0);
   endtask
   task automatic t_plain();
      dly = 4'h1;
      run(1'b0, 1'b0);
      $display("plain sequence done");
   endtask
   task automatic t_slow();
      dly = 4'h7;
      run(1'b0, 1'b1);
      $display("slow responses done");
   endtask
   task automatic t_block();
      dly = 4'h2;
      run(1'b1, 1'b0);
      $display("blocked fourth strobe done");
   endtask
   // earlier lock, further strobes, then a blocked split
   task automatic t_chain();
      dly = 4'h1;
      run(1'b0, 1'b0);
      run(1'b0, 1'b0);
      run(1'b1, 1'b0);
      $display("chained sequences done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         $display("Error %0t: timeout", $time);
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk) #1;
      t_plain();
      t_slow();
      t_block();
      t_chain();
      end_of_test();
   end
endmodule
